// >>> src/wkc_pkg.sv
package wkc_pkg;

   // -------------------------------------------------------------
   // Register indexes, byte address is four times the index
   // -------------------------------------------------------------
   localparam logic [9:0] IDX_MASK_COUNT = 10'h100;
   localparam logic [9:0] IDX_MASK_TIMER = 10'h101;
   localparam logic [9:0] IDX_COUNT_A = 10'h102;
   localparam logic [9:0] IDX_COUNT_B = 10'h103;
   localparam logic [9:0] IDX_THRESH_A = 10'h104;
   localparam logic [9:0] IDX_THRESH_B = 10'h105;
   localparam logic [9:0] IDX_IRQ_STATUS = 10'h110;
   localparam logic [9:0] IDX_STATE = 10'h111;
   localparam logic [9:0] IDX_COMMAND = 10'h112;
   localparam logic [9:0] IDX_CFG_UPPER = 10'h30c;
   localparam logic [9:0] IDX_CFG_LOWER = 10'h30d;
   localparam logic [9:0] IDX_RELOAD_UPPER = 10'h30e;
   localparam logic [9:0] IDX_RELOAD_LOWER = 10'h30f;

   // -------------------------------------------------------------
   // Fields, reset values and timing
   // -------------------------------------------------------------
   localparam int BIT_RC_ON = 6;
   localparam int BIT_XTAL_ON = 5;
   localparam int BIT_SRC_SEL = 4;
   localparam int BIT_RAM_KEEP = 3;
   localparam int BIT_ARM = 0;
   localparam int BIT_ST_TIMER = 0;
   localparam int BIT_ST_COUNT = 1;
   localparam int BIT_CMD_SLEEP = 0;
   localparam logic [7:0] CFG_LOWER_RST = 8'h00;
   localparam logic [2:0] DIV_SEL_RST = 3'h0;
   localparam logic [15:0] RELOAD_RST = 16'hffff;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam int SLOW_CLOCK_HZ = 32768;

   typedef enum {ST_ON, ST_SLEEP, ST_OFF} wkc_state_t;

   typedef struct packed {
      logic rc_on;
      logic xtal_on;
      logic src_rc;
      logic ram_keep;
      logic arm;
   } wkc_cfg_t;

   // Slow ticks per prescaled tick, minus one.
   function automatic logic [15:0] wkc_div_max(input logic [2:0] sel);
      case (sel)
         3'h0: wkc_div_max = 16'h0000;
         3'h1: wkc_div_max = 16'h0003;
         3'h2: wkc_div_max = 16'h0007;
         3'h3: wkc_div_max = 16'h000f;
         3'h4: wkc_div_max = 16'h007f;
         3'h5: wkc_div_max = 16'h03ff;
         3'h6: wkc_div_max = 16'h1fff;
         default: wkc_div_max = 16'hffff;
      endcase
   endfunction

endpackage

// >>> src/wkc_wake_controller.sv
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/100ps
module wkc_wake_controller
   import wkc_pkg::*;
(
   input wire logic clk_in,
   input wire logic resetn_in,
   input wire logic ce_in,
   input wire logic rc_clk_in,
   input wire logic xtal_clk_in,
   input wire logic awvalid_in,
   output logic awready_out,
   input wire logic [11:0] awaddr_in,
   input wire logic [2:0] awprot_in,
   input wire logic wvalid_in,
   output logic wready_out,
   input wire logic [31:0] wdata_in,
   input wire logic [3:0] wstrb_in,
   output logic bvalid_out,
   input wire logic bready_in,
   output logic [1:0] bresp_out,
   input wire logic arvalid_in,
   output logic arready_out,
   input wire logic [11:0] araddr_in,
   input wire logic [2:0] arprot_in,
   output logic rvalid_out,
   input wire logic rready_in,
   output logic [31:0] rdata_out,
   output logic [1:0] rresp_out,
   output logic irq_out,
   output logic rc_osc_on_out,
   output logic xtal_osc_on_out,
   output logic ram_power_out,
   output logic sleep_out,
   output logic off_out
);

   // -------------------------------------------------------------
   // Declarations
   // -------------------------------------------------------------
   logic aw_got, w_got, wr_en, wr_ok, rd_ok, wake, exceed, slow_edge, tick, expire;
   logic [9:0] aw_idx;
   logic [7:0] w_byte, cfg_upper_hold, reload_upper_hold, mask_count, mask_timer;
   logic [31:0] next_rdata;
   logic [2:0] div_sel, rc_sync, xt_sync;
   logic [15:0] reload, timer, pre_cnt, count, thresh, next_count;
   logic [1:0] status;
   wkc_cfg_t cfg;
   wkc_state_t state;

   // -------------------------------------------------------------
   // Register bus write side
   // -------------------------------------------------------------
   assign wr_en = ce_in && aw_got && w_got && !bvalid_out;
   assign wr_ok = wr_en && wstrb_in[0] == 1'b1;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         aw_got <= 1'b0;
         w_got <= 1'b0;
         awready_out <= 1'b0;
         wready_out <= 1'b0;
         bvalid_out <= 1'b0;
         bresp_out <= RESP_OKAY;
         aw_idx <= 10'h000;
         w_byte <= 8'h00;
      end else if (ce_in) begin
         awready_out <= !aw_got && !(awvalid_in && awready_out) && !bvalid_out;
         wready_out <= !w_got && !(wvalid_in && wready_out) && !bvalid_out;
         if (awvalid_in && awready_out) begin
            aw_got <= 1'b1;
            aw_idx <= awaddr_in[11:2];
         end
         if (wvalid_in && wready_out) begin
            w_got <= 1'b1;
            w_byte <= wdata_in[7:0];
         end
         if (wr_en) begin
            bvalid_out <= 1'b1;
            bresp_out <= (aw_idx == IDX_STATE || aw_idx == IDX_IRQ_STATUS
               || aw_idx == IDX_MASK_COUNT || aw_idx == IDX_MASK_TIMER
               || (aw_idx >= IDX_COUNT_A && aw_idx <= IDX_THRESH_B)
               || aw_idx == IDX_COMMAND
               || (aw_idx >= IDX_CFG_UPPER && aw_idx <= IDX_RELOAD_LOWER))
               ? RESP_OKAY : RESP_SLVERR;
         end else if (bvalid_out && bready_in) begin
            bvalid_out <= 1'b0;
            aw_got <= 1'b0;
            w_got <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Register bus read side
   // -------------------------------------------------------------
   always_comb begin
      rd_ok = 1'b1;
      next_rdata = 32'h00000000;
      case (araddr_in[11:2])
         IDX_MASK_COUNT: next_rdata[7:0] = mask_count;
         IDX_MASK_TIMER: next_rdata[7:0] = mask_timer;
         IDX_COUNT_A: next_rdata[7:0] = count[7:0];
         IDX_COUNT_B: next_rdata[7:0] = count[15:8];
         IDX_THRESH_A: next_rdata[7:0] = thresh[7:0];
         IDX_THRESH_B: next_rdata[7:0] = thresh[15:8];
         IDX_IRQ_STATUS: next_rdata[1:0] = status;
         IDX_STATE: next_rdata[1:0] = {state == ST_OFF, state == ST_SLEEP};
         IDX_COMMAND, IDX_CFG_UPPER, IDX_CFG_LOWER: next_rdata = 32'h00000000;
         IDX_RELOAD_UPPER, IDX_RELOAD_LOWER: next_rdata = 32'h00000000;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         arready_out <= 1'b0;
         rvalid_out <= 1'b0;
         rdata_out <= 32'h00000000;
         rresp_out <= RESP_OKAY;
      end else if (ce_in) begin
         arready_out <= !rvalid_out && !(arvalid_in && arready_out);
         if (arvalid_in && arready_out) begin
            rvalid_out <= 1'b1;
            rdata_out <= next_rdata;
            rresp_out <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid_out && rready_in) begin
            rvalid_out <= 1'b0;
         end
      end
   end

   // -------------------------------------------------------------
   // Configuration and reload pairs
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         cfg_upper_hold <= 8'h00;
         reload_upper_hold <= 8'h00;
         div_sel <= DIV_SEL_RST;
         cfg <= wkc_cfg_t'(5'h00);
         reload <= RELOAD_RST;
         mask_count <= 8'h00;
         mask_timer <= 8'h00;
         thresh <= 16'h0000;
      end else if (wr_ok) begin
         case (aw_idx)
            IDX_CFG_UPPER: cfg_upper_hold <= w_byte;
            IDX_CFG_LOWER: begin
               div_sel <= cfg_upper_hold[2:0];
               cfg.rc_on <= w_byte[BIT_RC_ON];
               cfg.xtal_on <= w_byte[BIT_XTAL_ON];
               cfg.src_rc <= w_byte[BIT_SRC_SEL];
               cfg.ram_keep <= w_byte[BIT_RAM_KEEP];
               cfg.arm <= w_byte[BIT_ARM];
            end
            IDX_RELOAD_UPPER: reload_upper_hold <= w_byte;
            IDX_RELOAD_LOWER: reload <= {reload_upper_hold, w_byte};
            IDX_MASK_COUNT: mask_count <= w_byte;
            IDX_MASK_TIMER: mask_timer <= w_byte;
            IDX_THRESH_A: thresh[7:0] <= w_byte;
            IDX_THRESH_B: thresh[15:8] <= w_byte;
            default: thresh <= thresh;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Slow clock selection and prescaler
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rc_sync <= 3'h0;
         xt_sync <= 3'h0;
      end else if (ce_in) begin
         rc_sync <= {rc_sync[1:0], rc_clk_in};
         xt_sync <= {xt_sync[1:0], xtal_clk_in};
      end
   end

   assign slow_edge = ce_in && (cfg.src_rc
      ? (cfg.rc_on && rc_sync[1] && !rc_sync[2])
      : (cfg.xtal_on && xt_sync[1] && !xt_sync[2]));
   assign tick = slow_edge && pre_cnt >= wkc_div_max(div_sel);
   assign expire = tick && timer <= 16'h0001;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         pre_cnt <= 16'h0000;
         timer <= RELOAD_RST;
      end else if (wr_ok && aw_idx == IDX_RELOAD_LOWER) begin
         pre_cnt <= 16'h0000;
         timer <= {reload_upper_hold, w_byte};
      end else begin
         if (slow_edge) begin
            pre_cnt <= tick ? 16'h0000 : pre_cnt + 16'h0001;
            if (expire) begin
               timer <= reload;
            end else if (tick) begin
               timer <= timer - 16'h0001;
            end
         end
         // A new divide ratio restarts the prescaler so it never sits beyond it.
         if (wr_ok && aw_idx == IDX_CFG_LOWER) begin
            pre_cnt <= 16'h0000;
         end
      end
   end

   // -------------------------------------------------------------
   // Power state and wake counting
   // -------------------------------------------------------------
   assign wake = expire && cfg.arm && state == ST_SLEEP;
   assign next_count = count + 16'h0001;
   assign exceed = next_count > thresh;

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         state <= ST_ON;
      end else if (ce_in) begin
         case (state)
            ST_SLEEP: begin
               if (wake && exceed) begin
                  state <= ST_OFF;
               end else begin
                  state <= ST_SLEEP;
               end
            end
            default: begin
               if (wr_ok && aw_idx == IDX_COMMAND && w_byte[BIT_CMD_SLEEP]) begin
                  state <= ST_SLEEP;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         count <= 16'h0000;
      end else if (wake) begin
         count <= exceed ? 16'h0000 : next_count;
      end else if (wr_ok && aw_idx == IDX_COUNT_A) begin
         count[7:0] <= w_byte;
      end else if (wr_ok && aw_idx == IDX_COUNT_B) begin
         count[15:8] <= w_byte;
      end
   end

   // -------------------------------------------------------------
   // Interrupt status, mask and outputs
   // -------------------------------------------------------------
   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         status <= 2'h0;
      end else if (ce_in) begin
         if (wr_ok && aw_idx == IDX_IRQ_STATUS) begin
            status <= status & ~w_byte[1:0];
         end
         if (wake) begin
            status[BIT_ST_TIMER] <= 1'b1;
            if (exceed) begin
               status[BIT_ST_COUNT] <= 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         irq_out <= 1'b0;
         rc_osc_on_out <= 1'b0;
         xtal_osc_on_out <= 1'b0;
         ram_power_out <= 1'b1;
         sleep_out <= 1'b0;
         off_out <= 1'b0;
      end else if (ce_in) begin
         irq_out <= (status[BIT_ST_TIMER] && mask_timer[BIT_ST_TIMER])
            || (status[BIT_ST_COUNT] && mask_count[BIT_ST_COUNT]);
         rc_osc_on_out <= cfg.rc_on;
         xtal_osc_on_out <= cfg.xtal_on;
         ram_power_out <= state != ST_SLEEP || cfg.ram_keep;
         sleep_out <= state == ST_SLEEP;
         off_out <= state == ST_OFF;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!resetn_in);

   a_reload_pair: assert property (wr_ok && aw_idx == IDX_RELOAD_LOWER
      |=> reload == {$past(reload_upper_hold), $past(w_byte)} && timer == reload)
      else $error("reload pair not loaded");
   a_prescale_bound: assert property (pre_cnt <= wkc_div_max(div_sel))
      else $error("prescaler beyond divide ratio");
   a_timer_step: assert property (tick && !expire && !(wr_ok && aw_idx == IDX_RELOAD_LOWER)
      |=> timer == $past(timer) - 16'h0001)
      else $error("timer did not step on tick");
   a_osc_enables: assert property (ce_in |=> rc_osc_on_out == $past(cfg.rc_on)
      && xtal_osc_on_out == $past(cfg.xtal_on))
      else $error("oscillator enable mismatch");
   a_source_select: assert property (slow_edge |-> (cfg.src_rc ? rc_sync[1] : xt_sync[1]))
      else $error("tick from unselected oscillator");
   a_ram_power: assert property (ce_in && state == ST_SLEEP && !cfg.ram_keep
      |=> !ram_power_out)
      else $error("retention power kept while disabled");
   a_unarmed_sleep: assert property (ce_in && state == ST_SLEEP && !cfg.arm
      |=> state == ST_SLEEP && $stable(count))
      else $error("unarmed expiry woke device");
   a_count_step: assert property (wake && !exceed |=> count == $past(count) + 16'h0001
      && state == ST_SLEEP)
      else $error("wake count not incremented");
   a_count_clear: assert property (wake && exceed |=> count == 16'h0000
      ##1 off_out && !sleep_out)
      else $error("overflow did not clear and power off");
   a_count_irq: assert property (ce_in && status[BIT_ST_COUNT] && !mask_count[BIT_ST_COUNT]
      && !(status[BIT_ST_TIMER] && mask_timer[BIT_ST_TIMER]) |=> !irq_out)
      else $error("masked wake count interrupt raised");
   a_timer_irq: assert property (wake && mask_timer[BIT_ST_TIMER]
      && !(wr_ok && aw_idx == IDX_MASK_TIMER) |=> ##1 irq_out)
      else $error("timer interrupt missing on wake");

   c_wake_resleep: cover property (wake && !exceed ##1 state == ST_SLEEP);
   c_wake_off: cover property (wake && exceed ##[1:4] off_out);
   c_irq_raise: cover property ($rose(irq_out));

endmodule // wkc_wake_controller

// >>> tb/wkc_osc_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Slow oscillator pair feeding the wake controller.
// ----------------------------------------------------------------
// The slow clocks run far faster than in silicon to keep runs short.
module wkc_osc_model #(
   parameter real HALF_NS = 20.0
) (
   input wire logic rc_on_in,
   input wire logic xtal_on_in,
   output logic rc_clk_out,
   output logic xtal_clk_out
);
   // A disabled oscillator holds its output low.
   initial begin
      rc_clk_out = 1'b0;
      #1.3;
      forever begin
         #(HALF_NS);
         rc_clk_out = rc_on_in ? ~rc_clk_out : 1'b0;
      end
   end
   initial begin
      xtal_clk_out = 1'b0;
      #3.7;
      forever begin
         #(HALF_NS);
         xtal_clk_out = xtal_on_in ? ~xtal_clk_out : 1'b0;
      end
   end
endmodule // wkc_osc_model

// >>> tb/wkc_wake_controller_tb.sv
`timescale 1ns/100ps
module wkc_wake_controller_tb;
   import wkc_pkg::*;
   logic clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic ce_in = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [2:0] awprot = 3'h0, arprot = 3'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   wire logic awready, wready, bvalid, arready, rvalid, irq;
   wire logic rc_on, xt_on, ram_pw, slp, off, rc_clk, xt_clk;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   logic [31:0] seed = 32'h0000db64;
   int num_errors = 0, n_checks = 0, cyc = 0, mdl_cnt = 0, mdl_thr = 0;
   int div[8] = '{1, 4, 8, 16, 128, 1024, 8192, 65536};

   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) cyc <= cyc + 1;

   wkc_wake_controller dut_u (.clk_in(clk_in), .resetn_in(resetn_in), .ce_in(ce_in),
      .rc_clk_in(rc_clk), .xtal_clk_in(xt_clk), .awvalid_in(awvalid), .awready_out(awready),
      .awaddr_in(awaddr), .awprot_in(awprot), .wvalid_in(wvalid), .wready_out(wready),
      .wdata_in(wdata), .wstrb_in(wstrb), .bvalid_out(bvalid), .bready_in(bready),
      .bresp_out(bresp), .arvalid_in(arvalid), .arready_out(arready), .araddr_in(araddr),
      .arprot_in(arprot), .rvalid_out(rvalid), .rready_in(rready), .rdata_out(rdata),
      .rresp_out(rresp), .irq_out(irq), .rc_osc_on_out(rc_on), .xtal_osc_on_out(xt_on),
      .ram_power_out(ram_pw), .sleep_out(slp), .off_out(off));

   wkc_osc_model osc_u (.rc_on_in(rc_on), .xtal_on_in(xt_on), .rc_clk_out(rc_clk),
      .xtal_clk_out(xt_clk));

   // ----------------------------------------------------------------
   // Helpers.
   // ----------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   task automatic end_sim();
      $display("Checks: %0d, errors: %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic guard(inout int n);
      n++;
      if (n > 40000) begin
         num_errors++;
         end_sim();
      end
   endtask

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic a, w;
      int n;
      a = 1'b0;
      w = 1'b0;
      n = 0;
      @(posedge clk_in);
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      awaddr <= {idx, 2'h0};
      awprot <= 3'(xs());
      wdata <= (xs() & 32'hffffff00) | {24'h0, d};
      while (!(a && w)) begin
         @(posedge clk_in);
         guard(n);
         if (awvalid && awready === 1'b1) begin
            a = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) begin
         @(posedge clk_in);
         guard(n);
      end
      chk("bresp", bresp, RESP_OKAY);
      bready <= 1'b0;
   endtask

   task automatic rdc(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      int n;
      n = 0;
      @(posedge clk_in);
      arvalid <= 1'b1;
      rready <= 1'b1;
      araddr <= {idx, 2'h0};
      arprot <= 3'(xs());
      do begin
         @(posedge clk_in);
         guard(n);
      end while (arready !== 1'b1);
      arvalid <= 1'b0;
      do begin
         @(posedge clk_in);
         guard(n);
      end while (rvalid !== 1'b1);
      chk("rresp", rresp, er);
      chk("rdata", rdata, exp);
      rready <= 1'b0;
   endtask

   task automatic wait_irq(output int t);
      int n;
      n = 0;
      while (irq !== 1'b1) begin
         @(posedge clk_in);
         guard(n);
      end
      t = cyc;
   endtask

   // Reference wake handling: count, compare with threshold, wrap.
   task automatic mdl_wake();
      mdl_cnt++;
      if (mdl_cnt > mdl_thr) mdl_cnt = 0;
   endtask

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      logic [2:0] code;
      logic [7:0] cfg;
      logic [15:0] rel;
      int t1, t2, e;
      repeat (2) @(posedge clk_in);
      resetn_in <= 1'b1;
      @(posedge clk_in);
      chk("irq", irq, 0);
      chk("ram_pw", ram_pw, 1);
      chk("state", {off, slp}, 0);
      rdc(IDX_STATE, 0);
      rdc(10'h000, 0, RESP_SLVERR);
      wstrb <= 4'he;
      wr(IDX_COUNT_A, 8'h55);
      wstrb <= 4'hf;
      rdc(IDX_COUNT_A, 0);
      wr(IDX_MASK_COUNT, 8'h02);
      wr(IDX_MASK_TIMER, 8'h01);
      for (int c = 0; c < 6; c++) begin
         code = 3'(c);
         rel = (c < 4) ? 16'(4 + (xs() & 3)) : 16'h0002;
         cfg = {1'b0, ~code[0], code[0], ~code[0], code[1], 2'h0, 1'b1};
         wr(IDX_IRQ_STATUS, 8'h03);
         wr(IDX_CFG_UPPER, {5'h0, code});
         wr(IDX_CFG_LOWER, cfg);
         rdc(IDX_CFG_LOWER, 0);
         chk("rc_on", rc_on, cfg[6]);
         chk("xt_on", xt_on, cfg[5]);
         wr(IDX_THRESH_A, 8'h01);
         wr(IDX_THRESH_B, 8'h00);
         wr(IDX_COUNT_A, 8'h00);
         wr(IDX_COUNT_B, 8'h00);
         mdl_cnt = 0;
         mdl_thr = 1;
         wr(IDX_RELOAD_UPPER, rel[15:8]);
         wr(IDX_RELOAD_LOWER, rel[7:0]);
         wr(IDX_COMMAND, 8'h01);
         repeat (2) @(posedge clk_in);
         chk("sleep", {off, slp}, 1);
         chk("ram_pw", ram_pw, cfg[3]);
         wait_irq(t1);
         mdl_wake();
         chk("sleep", {off, slp}, 1);
         rdc(IDX_COUNT_A, 32'(mdl_cnt));
         rdc(IDX_IRQ_STATUS, 1);
         wr(IDX_IRQ_STATUS, 8'h01);
         repeat (2) @(posedge clk_in);
         chk("irq", irq, 0);
         wait_irq(t2);
         mdl_wake();
         e = int'(rel) * div[c] * 8;
         chk("interval", 32'(t2 - t1), 32'(e));
         chk("off", {off, slp}, 2);
         rdc(IDX_COUNT_A, 32'(mdl_cnt));
         rdc(IDX_COUNT_B, 0);
         rdc(IDX_IRQ_STATUS, 3);
      end
      wr(IDX_IRQ_STATUS, 8'h03);
      wr(IDX_CFG_UPPER, 8'h00);
      wr(IDX_CFG_LOWER, 8'h50);
      wr(IDX_RELOAD_UPPER, 8'h00);
      wr(IDX_RELOAD_LOWER, 8'h04);
      wr(IDX_COMMAND, 8'h01);
      repeat (300) @(posedge clk_in);
      chk("irq", irq, 0);
      chk("sleep", {off, slp}, 1);
      rdc(IDX_COUNT_A, 0);
      end_sim();
   end

   initial begin
      repeat (100000) @(posedge clk_in);
      num_errors++;
      end_sim();
   end
endmodule // wkc_wake_controller_tb
